// ---- core/brhg_pkg.sv ----
// Purpose: Constants for the two-wire bit-rate and hold-time generator
// Assumes: Rate codes 0x00 to 0x1F only; upper codes map to the last entry
// Notes: Rate table packs divider, data hold, start hold, stop hold
package brhg_pkg;
    // ==========================================================
    // Register map and fields
    localparam logic [1:0] BRHG_ADDR_DIVIDER = 2'h0;
    localparam logic [1:0] BRHG_ADDR_STATUS = 2'h1;
    localparam int BRHG_RATE_MULTIPLIER_MSB = 7;
    localparam int BRHG_RATE_MULTIPLIER_LSB = 6;
    localparam int BRHG_CODE_MSB = 5;
    localparam logic [7:0] BRHG_DIVIDER_RESET = 8'h00;
    localparam logic [1:0] BRHG_RATE_MULTIPLIER_RESERVED = 2'h3;
    // ==========================================================
    // Rate table: {divider, data hold, start hold, stop hold}, 8 bits each
    localparam int BRHG_TABLE_SIZE = 32;
    localparam logic [31:0] BRHG_TABLE [0:31] = '{
        {8'd20, 8'd7, 8'd6, 8'd11}, {8'd22, 8'd7, 8'd7, 8'd12},
        {8'd24, 8'd8, 8'd8, 8'd13}, {8'd26, 8'd8, 8'd9, 8'd14},
        {8'd28, 8'd9, 8'd10, 8'd15}, {8'd30, 8'd9, 8'd11, 8'd16},
        {8'd34, 8'd10, 8'd13, 8'd18}, {8'd40, 8'd10, 8'd16, 8'd21},
        {8'd28, 8'd7, 8'd10, 8'd15}, {8'd32, 8'd7, 8'd12, 8'd17},
        {8'd36, 8'd9, 8'd14, 8'd19}, {8'd40, 8'd9, 8'd16, 8'd21},
        {8'd44, 8'd11, 8'd18, 8'd23}, {8'd48, 8'd11, 8'd20, 8'd25},
        {8'd56, 8'd13, 8'd24, 8'd29}, {8'd68, 8'd13, 8'd30, 8'd35},
        {8'd48, 8'd9, 8'd18, 8'd25}, {8'd56, 8'd9, 8'd22, 8'd29},
        {8'd64, 8'd13, 8'd26, 8'd33}, {8'd72, 8'd13, 8'd30, 8'd37},
        {8'd80, 8'd17, 8'd34, 8'd41}, {8'd88, 8'd17, 8'd38, 8'd45},
        {8'd104, 8'd21, 8'd46, 8'd53}, {8'd128, 8'd21, 8'd58, 8'd65},
        {8'd80, 8'd9, 8'd38, 8'd41}, {8'd96, 8'd9, 8'd46, 8'd49},
        {8'd112, 8'd17, 8'd54, 8'd57}, {8'd128, 8'd17, 8'd62, 8'd65},
        {8'd144, 8'd25, 8'd70, 8'd73}, {8'd160, 8'd25, 8'd78, 8'd81},
        {8'd192, 8'd33, 8'd94, 8'd97}, {8'd240, 8'd33, 8'd118, 8'd121}
    };
    // ==========================================================
    // Timed phases
    typedef enum logic [2:0] {
        BRHG_IDLE = 3'b000,
        BRHG_HALF = 3'b001,
        BRHG_DATA = 3'b010,
        BRHG_START = 3'b011,
        BRHG_STOP = 3'b100
    } brhg_phase_t;
endpackage

// ---- core/brhg_core.sv ----
// Purpose: Bit-rate divider and hold-time timer for the two-wire interface
// Assumes: Sequencer requests timed phases with one-cycle pulses
// Notes: One down-counter serves every phase
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module brhg_core (
    input wire logic mclk, // 25 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [1:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic half_req, // Start a half serial clock period
    input wire logic data_req, // Start data hold after clock fall
    input wire logic start_req, // Start start hold after data fall
    input wire logic stop_req, // Start stop hold after clock rise
    output logic busy, // A phase is being timed
    output logic done, // Pulse when the timed phase ends
    output logic [11:0] bit_period // Bus cycles per serial bit
);
    // ==========================================================
    // Divider register
    logic [7:0] bit_rate_divider;
    logic [1:0] rate_multiplier;
    logic [4:0] clock_rate_code;
    logic [2:0] factor;
    logic [31:0] entry;
    logic [11:0] next_load;
    brhg_pkg::brhg_phase_t phase;
    logic [11:0] count;

    assign rate_multiplier = bit_rate_divider[brhg_pkg::BRHG_RATE_MULTIPLIER_MSB:brhg_pkg::BRHG_RATE_MULTIPLIER_LSB];
    // Upper codes lie outside the table and saturate at the last row
    assign clock_rate_code = bit_rate_divider[brhg_pkg::BRHG_CODE_MSB] ? 5'h1F
                             : bit_rate_divider[4:0];

    // Software write of the divider register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bit_rate_divider <= brhg_pkg::BRHG_DIVIDER_RESET;
        end else if (reg_wr && reg_addr == brhg_pkg::BRHG_ADDR_DIVIDER) begin
            bit_rate_divider <= reg_wdata;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == brhg_pkg::BRHG_ADDR_DIVIDER) begin
            reg_rdata <= bit_rate_divider;
        end else if (reg_rd && reg_addr == brhg_pkg::BRHG_ADDR_STATUS) begin
            reg_rdata <= {5'h00, phase};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Factor decode and table lookup
    always_comb begin
        case (rate_multiplier)
            2'h0: factor = 3'd1;
            2'h1: factor = 3'd2;
            2'h2: factor = 3'd4;
            brhg_pkg::BRHG_RATE_MULTIPLIER_RESERVED: factor = 3'd1; // Reserved code treated as factor 1
            default: factor = 3'd1;
        endcase
    end
    assign entry = brhg_pkg::BRHG_TABLE[clock_rate_code];

    // Reload value: factor times the selected table field, halved for a half period request
    always_comb begin
        next_load = 12'h000;
        if (half_req) begin
            next_load = (12'(factor) * 12'(entry[31:24])) >> 1;
        end else if (data_req) begin
            next_load = 12'(factor) * 12'(entry[23:16]);
        end else if (start_req) begin
            next_load = 12'(factor) * 12'(entry[15:8]);
        end else if (stop_req) begin
            next_load = 12'(factor) * 12'(entry[7:0]);
        end
    end

    // ==========================================================
    // Single phase counter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase <= brhg_pkg::BRHG_IDLE;
            count <= 12'h000;
            done <= 1'b0;
            busy <= 1'b0;
        end else if (phase == brhg_pkg::BRHG_IDLE) begin
            done <= 1'b0;
            if (half_req || data_req || start_req || stop_req) begin
                count <= next_load;
                busy <= 1'b1;
                if (half_req) phase <= brhg_pkg::BRHG_HALF;
                else if (data_req) phase <= brhg_pkg::BRHG_DATA;
                else if (start_req) phase <= brhg_pkg::BRHG_START;
                else phase <= brhg_pkg::BRHG_STOP;
            end
        end else if (count <= 12'h001) begin
            phase <= brhg_pkg::BRHG_IDLE;
            done <= 1'b1;
            busy <= 1'b0;
            count <= 12'h000;
        end else begin
            count <= count - 12'h001;
        end
    end

    // Full bit period for the sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bit_period <= 12'h000;
        end else begin
            bit_period <= 12'(factor) * 12'(entry[31:24]);
        end
    end

    // ==========================================================
    // Checks
    property p_period;
        @(posedge mclk) disable iff (sys_rst)
        (rate_multiplier == 2'h0 && clock_rate_code == 5'h00) |=> bit_period == 12'd20;
    endproperty
    a_period: assert property (p_period) else $error("bit period wrong");
    property p_rate_multiplier;
        @(posedge mclk) disable iff (sys_rst)
        (rate_multiplier == 2'h2 && clock_rate_code == 5'h1F) |=> bit_period == 12'd960;
    endproperty
    a_rate_multiplier: assert property (p_rate_multiplier) else $error("factor four wrong");
    property p_data;
        @(posedge mclk) disable iff (sys_rst)
        (phase == brhg_pkg::BRHG_IDLE && data_req && !half_req && factor == 3'd1
         && clock_rate_code == 5'h00) |=> busy [*7] ##1 done;
    endproperty
    a_data: assert property (p_data) else $error("data hold length wrong");
    property p_start;
        @(posedge mclk) disable iff (sys_rst)
        (phase == brhg_pkg::BRHG_IDLE && start_req && !half_req && !data_req
         && factor == 3'd1 && clock_rate_code == 5'h00) |=> busy [*6] ##1 done;
    endproperty
    a_start: assert property (p_start) else $error("start hold length wrong");
    property p_stop;
        @(posedge mclk) disable iff (sys_rst)
        (phase == brhg_pkg::BRHG_STOP && count == 12'd11) |-> ##11 done;
    endproperty
    a_stop: assert property (p_stop) else $error("stop hold length wrong");
    property p_table;
        @(posedge mclk) disable iff (sys_rst)
        clock_rate_code == 5'h1F |-> entry == {8'd240, 8'd33, 8'd118, 8'd121};
    endproperty
    a_table: assert property (p_table) else $error("table row wrong");
    property p_code;
        @(posedge mclk) disable iff (sys_rst)
        !bit_rate_divider[5] |-> clock_rate_code == bit_rate_divider[4:0];
    endproperty
    a_code: assert property (p_code) else $error("code select wrong");
    property p_count;
        @(posedge mclk) disable iff (sys_rst)
        (phase != brhg_pkg::BRHG_IDLE && count > 12'h001) |=> count == $past(count) - 12'h001;
    endproperty
    a_count: assert property (p_count) else $error("counter not stepping");
    property p_half;
        @(posedge mclk) disable iff (sys_rst)
        (phase == brhg_pkg::BRHG_IDLE && half_req && factor == 3'd1
         && clock_rate_code == 5'h00) |=> busy [*8] ##1 busy ##1 busy ##1 done;
    endproperty
    a_half: assert property (p_half) else $error("half period length wrong");
    property p_refuse;
        @(posedge mclk) disable iff (sys_rst)
        (phase != brhg_pkg::BRHG_IDLE && count > 12'h001
         && (half_req || data_req || start_req || stop_req)) |=> phase == $past(phase);
    endproperty
    a_refuse: assert property (p_refuse) else $error("request taken while busy");
    property p_done_pulse;
        @(posedge mclk) disable iff (sys_rst)
        done |-> !busy ##1 !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
    property p_factor2;
        @(posedge mclk) disable iff (sys_rst)
        rate_multiplier == 2'h1 |-> factor == 3'd2;
    endproperty
    a_factor2: assert property (p_factor2) else $error("factor two wrong");
    property p_rdata;
        @(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == brhg_pkg::BRHG_ADDR_DIVIDER)
        |=> reg_rdata == $past(bit_rate_divider);
    endproperty
    a_rdata: assert property (p_rdata) else $error("divider read data wrong");
    property p_rdata_idle;
        @(posedge mclk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    // ==========================================================
    // Check helper: busy cycles of a phase against the load it took
    logic [11:0] chk_load;
    logic [11:0] chk_run;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            chk_load <= 12'h000;
            chk_run <= 12'h000;
        end else if (phase == brhg_pkg::BRHG_IDLE) begin
            chk_load <= next_load;
            chk_run <= 12'h000;
        end else begin
            chk_run <= chk_run + 12'h001;
        end
    end
    property p_length;
        @(posedge mclk) disable iff (sys_rst)
        done |-> (chk_run == chk_load || (chk_load <= 12'h001 && chk_run == 12'h001));
    endproperty
    a_length: assert property (p_length) else $error("phase length not the load");
    c_data: cover property (@(posedge mclk) phase == brhg_pkg::BRHG_DATA ##[1:200] done);
    c_start: cover property (@(posedge mclk) phase == brhg_pkg::BRHG_START ##[1:200] done);
    c_stop: cover property (@(posedge mclk) phase == brhg_pkg::BRHG_STOP ##[1:200] done);
    c_half: cover property (@(posedge mclk) phase == brhg_pkg::BRHG_HALF ##[1:500] done);
    c_refuse: cover property (@(posedge mclk)
        busy && (half_req || data_req || start_req || stop_req));
endmodule
`default_nettype wire

// ---- bench/brhg_seq_model.sv ----
// Purpose: Sequencer model that requests timed phases and measures them
// Assumes: go is one cycle; kind 0 half, 1 data, 2 start, 3 stop
// Notes: A request while measuring is sent but not measured
`timescale 1ns/10ps
`default_nettype none
module brhg_seq_model (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic go, // Issue a request
    input wire logic [1:0] kind, // Phase kind
    input wire logic busy, // Timer busy
    input wire logic done, // Timer done
    output logic [3:0] req, // One-hot requests, half at bit 0
    output logic fin, // Phase measured
    output int span // Busy cycles seen
);
    // ==========================================
    // Request pulses and busy cycle counter
    logic run;
    always_ff @(posedge mclk) begin
        req <= (go && !sys_rst) ? 4'h1 << kind : 4'h0;
        fin <= 1'b0;
        if (sys_rst) begin
            run <= 1'b0;
            span <= 0;
        end else if (go && !run) begin
            run <= 1'b1;
            span <= 0;
        end else if (run && done) begin
            run <= 1'b0;
            fin <= 1'b1;
        end else if (run && busy) begin
            span <= span + 1;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the bit-rate and hold-time generator
// Assumes: Multiplier code 3 is never programmed
// Notes: Expected counts come from an integer model of the rate rules
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ==========================================
    // Clock, stimulus and hookup
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [7:0] reg_rdata, s;
    logic [3:0] req;
    logic busy, done, fin;
    logic [11:0] bit_period;
    int span, i, errors = 0, checks = 0, seed = 32'hcbc7;
    always #20 mclk = ~mclk;
    brhg_core DUT (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .half_req(req[0]),
        .data_req(req[1]), .start_req(req[2]), .stop_req(req[3]), .busy(busy), .done(done),
        .bit_period(bit_period));
    brhg_seq_model SEQ (.mclk(mclk), .sys_rst(sys_rst), .go(go), .kind(kind), .busy(busy),
        .done(done), .req(req), .fin(fin), .span(span));
    // ==========================================
    // Shared tasks
    task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (exp !== got) begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One phase, with a refused second request while it is timed
    task automatic phase(input logic [1:0] k, input int n);
        logic [7:0] st;
        int t;
        @(posedge mclk);
        go <= 1'b1;
        kind <= k;
        @(posedge mclk);
        go <= 1'b0;
        rd(2'h1, st);
        compare("status busy", k + 1, st);
        @(posedge mclk);
        go <= 1'b1;
        kind <= ~k;
        @(posedge mclk);
        go <= 1'b0;
        for (t = 0; t < 4000 && fin !== 1'b1; t++) @(negedge mclk);
        compare("phase end", 1, fin);
        compare("phase span", n, span);
        rd(2'h1, st);
        compare("status idle", 0, st);
    endtask
    task automatic setting(input int m, input int c);
        logic [7:0] v;
        logic [31:0] r;
        int f;
        f = (m == 2) ? 4 : m + 1;
        r = brhg_pkg::BRHG_TABLE[c];
        wr(2'h0, {m[1:0], c[5:0]});
        rd(2'h0, v);
        compare("divider", {m[1:0], c[5:0]}, v);
        compare("bit period", f * r[31:24], bit_period);
        phase(2'h0, (f * r[31:24]) >> 1);
        phase(2'h1, f * r[23:16]);
        phase(2'h2, f * r[15:8]);
        phase(2'h3, f * r[7:0]);
        $display("setting rate_multiplier %0d code %0d done", m, c);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(2'h0, s);
        compare("reset divider", 0, s);
        compare("reset period", 20, bit_period);
        setting(0, 0);
        compare("row 00 period", 20, bit_period);
        for (i = 1; i < 31; i++) setting($unsigned($random(seed)) % 3, i);
        for (i = 0; i < 3; i++) setting(i, $unsigned($random(seed)) % 32);
        setting(2, 31);
        compare("row 1F period", 960, bit_period);
        wr(2'h3, 8'($random(seed)));
        rd(2'h3, s);
        compare("unmapped read", 0, s);
        rd(2'h0, s);
        compare("divider kept", 8'h9F, s);
        wr(2'h0, 8'h25);
        rd(2'h0, s);
        compare("saturated divider", 8'h25, s);
        compare("saturated period", 240, bit_period);
        $display("unmapped and saturated codes done");
        results;
    end
    initial begin
        #2000000;
        errors++;
        results;
    end
endmodule
`default_nettype wire
